// file: tag_prio_pkg.sv
// Package with register map, field layout and reset values of the tag priority map
package tag_prio_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_TAG_MAP_LOWER = 8'h80;
	localparam logic [7:0] IDX_TAG_MAP_UPPER = 8'h81;
	localparam logic [7:0] IDX_FOLD_CONTROL = 8'h82;
	localparam logic [7:0] IDX_QUEUE_CONFIG = 8'h83;
	localparam logic [7:0] IDX_CLASS_STATUS = 8'h84;
	localparam int BUS_ADDR_W = 10;
	// Field positions inside the upper map register
	localparam int POS_TAG_SEVEN = 6;
	localparam int POS_TAG_SIX = 4;
	localparam int POS_TAG_FIVE = 2;
	localparam int POS_TAG_FOUR = 0;
	// Field position of the fold selector inside the fold control register
	localparam int POS_FOLD_SEL = 0;
	// Reset values
	localparam logic [7:0] RST_TAG_MAP_LOWER = 8'h50;
	localparam logic [1:0] RST_TAG_SEVEN = 2'h3;
	localparam logic [1:0] RST_TAG_SIX = 2'h3;
	localparam logic [1:0] RST_TAG_FIVE = 2'h2;
	localparam logic [1:0] RST_TAG_FOUR = 2'h2;
	localparam logic [1:0] RST_FOLD_SEL = 2'h2;
	localparam logic [7:0] RST_TAG_MAP_UPPER = {RST_TAG_SEVEN, RST_TAG_SIX,
		RST_TAG_FIVE, RST_TAG_FOUR};
	localparam logic [7:0] RST_FOLD_CONTROL = {6'h00, RST_FOLD_SEL};
	localparam logic [7:0] RST_QUEUE_CONFIG = 8'h00;
	// Fold selector encodings
	localparam logic [1:0] FOLD_ONLY_THREE = 2'h0;
	localparam logic [1:0] FOLD_TWO_UP = 2'h2;
	localparam logic [1:0] FOLD_ONE_UP = 2'h3;
	// Bus answer states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;
endpackage : tag_prio_pkg

// file: prio_cfg_if.sv
// Interface carrying mapping configuration from register file to classifier
`timescale 1ns/1ps
`default_nettype none
interface prio_cfg_if;
	logic [15:0] tag_table;
	logic [1:0] fold_sel;
	logic two_queue_mode;
	modport regs (output tag_table, output fold_sel, output two_queue_mode);
	modport cls (input tag_table, input fold_sel, input two_queue_mode);
endinterface : prio_cfg_if
`default_nettype wire

// file: prio_fold.sv
// Two-queue fold of a 2-bit priority result into low or high queue
`timescale 1ns/1ps
`default_nettype none
module prio_fold
	import tag_prio_pkg::*;
(
	input wire logic [1:0] result_i, // 2-bit priority result
	input wire logic [1:0] sel_i, // Fold selector
	output logic high_o // High when the result goes to the high queue
);
	// Threshold compare; the spare code 01 is handled like 10
	wire logic [1:0] threshold;
	assign threshold = (sel_i == FOLD_ONLY_THREE) ? 2'h3 :
		(sel_i == FOLD_ONE_UP) ? 2'h1 : 2'h2;
	assign high_o = (result_i >= threshold);
endmodule : prio_fold
`default_nettype wire

// file: tag_priority_queue_map.sv
// Wishbone register bank and classifier for tag to priority queue mapping
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tag_priority_queue_map
	import tag_prio_pkg::*;
(
	input wire logic clk_i, // Core clock, 200 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic ce_i, // Clock enable, freezes all state when low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [BUS_ADDR_W-1:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	output logic wb_err_o, // Wishbone error for unmapped address
	input wire logic frm_valid_i, // Frame classification request
	input wire logic frm_tagged_i, // Frame carries an 802.1p tag
	input wire logic [2:0] frm_tag_i, // 802.1p priority tag
	input wire logic frm_use_ds_i, // Use DiffServ result instead of tag
	input wire logic [1:0] frm_ds_prio_i, // Result of DiffServ table
	output logic cls_valid_o, // Classification result valid
	output logic [1:0] cls_prio_o, // 2-bit internal priority
	output logic cls_high_o // Queue select in two-queue mode
);
	prio_cfg_if cfg ();

	logic [7:0] map_lower_reg;
	logic [7:0] map_upper_reg;
	logic [7:0] fold_ctrl_reg;
	logic [7:0] queue_cfg_reg;
	logic [7:0] status_reg;
	logic [31:0] dat_reg;
	logic ack_reg;
	logic err_reg;
	logic cls_valid_reg;
	logic [1:0] cls_prio_reg;
	logic cls_high_reg;
	bus_state_t state_reg;
	bus_state_t state_next;

	// Address decode; registers take one aligned word at four times the index
	wire logic [7:0] word_idx;
	wire logic addr_ok;
	wire logic req;
	wire logic wr_fire;
	wire logic hit_lower;
	wire logic hit_upper;
	wire logic hit_fold;
	wire logic hit_qcfg;
	wire logic hit_stat;
	assign word_idx = wb_adr_i[BUS_ADDR_W-1:2];
	assign hit_lower = (word_idx == IDX_TAG_MAP_LOWER);
	assign hit_upper = (word_idx == IDX_TAG_MAP_UPPER);
	assign hit_fold = (word_idx == IDX_FOLD_CONTROL);
	assign hit_qcfg = (word_idx == IDX_QUEUE_CONFIG);
	assign hit_stat = (word_idx == IDX_CLASS_STATUS);
	assign addr_ok = hit_lower | hit_upper | hit_fold | hit_qcfg | hit_stat;
	assign req = wb_cyc_i & wb_stb_i & (state_reg == BUS_IDLE);
	// Only byte lane 0 holds data; wider lanes are ignored
	assign wr_fire = req & wb_we_i & wb_sel_i[0] & addr_ok;

	// Read multiplexer; bits above the 8-bit register read as zero
	wire logic [7:0] rd_byte;
	assign rd_byte = hit_lower ? map_lower_reg :
		hit_upper ? map_upper_reg :
		hit_fold ? fold_ctrl_reg :
		hit_qcfg ? queue_cfg_reg :
		hit_stat ? status_reg : 8'h00;

	// One-cycle answer, then one idle cycle so ack drops after each access
	assign state_next = (state_reg == BUS_IDLE) ?
		(req ? BUS_ACK : BUS_IDLE) : BUS_IDLE;

	// Bus state and answer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= BUS_IDLE;
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			state_reg <= state_next;
			ack_reg <= req & addr_ok;
			err_reg <= req & ~addr_ok;
			dat_reg <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// Configuration registers; fields reset to their defaults
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			map_lower_reg <= RST_TAG_MAP_LOWER;
			map_upper_reg <= RST_TAG_MAP_UPPER;
			fold_ctrl_reg <= RST_FOLD_CONTROL;
			queue_cfg_reg <= RST_QUEUE_CONFIG;
		end else if (ce_i && wr_fire) begin
			if (hit_lower)
				map_lower_reg <= wb_dat_i[7:0];
			if (hit_upper)
				map_upper_reg <= wb_dat_i[7:0];
			if (hit_fold)
				fold_ctrl_reg <= {6'h00, wb_dat_i[1:0]};
			if (hit_qcfg)
				queue_cfg_reg <= {7'h00, wb_dat_i[0]};
		end
	end

	// Export configuration to the classifier
	assign cfg.tag_table = {map_upper_reg, map_lower_reg};
	assign cfg.fold_sel = fold_ctrl_reg[POS_FOLD_SEL +: 2];
	assign cfg.two_queue_mode = queue_cfg_reg[0];

	// Tag lookup: the field for tag n sits at bits 2n+1..2n
	wire logic [1:0] tag_prio;
	wire logic [1:0] src_prio;
	wire logic fold_high;
	assign tag_prio = cfg.tag_table[{frm_tag_i, 1'b0} +: 2];
	// Untagged or DiffServ frames take the DiffServ result
	assign src_prio = (frm_use_ds_i | ~frm_tagged_i) ?
		frm_ds_prio_i : tag_prio;

	prio_fold u_fold (
		.result_i(src_prio),
		.sel_i(cfg.fold_sel),
		.high_o(fold_high)
	);

	// Registered classification output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cls_valid_reg <= 1'b0;
			cls_prio_reg <= 2'h0;
			cls_high_reg <= 1'b0;
		end else if (ce_i) begin
			cls_valid_reg <= frm_valid_i;
			cls_prio_reg <= src_prio;
			// Four-queue mode leaves the fold out entirely
			cls_high_reg <= cfg.two_queue_mode & fold_high;
		end
	end

	// Status shows the last classification for software
	always_ff @(posedge clk_i) begin
		if (rst_i)
			status_reg <= 8'h00;
		else if (ce_i && cls_valid_reg)
			status_reg <= {5'h00, cls_high_reg, cls_prio_reg};
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign cls_valid_o = cls_valid_reg;
	assign cls_prio_o = cls_prio_reg;
	assign cls_high_o = cls_high_reg;

	// Checks on the classifier path
	property p_tag_lookup;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && frm_valid_i && frm_tagged_i && !frm_use_ds_i |=>
			cls_prio_o == $past(map_upper_reg[7:6]) || $past(frm_tag_i) != 3'h7;
	endproperty
	a_tag_lookup: assert property (p_tag_lookup)
		else $error("tag seven lookup wrong");

	property p_reset_upper;
		@(posedge clk_i) rst_i && ce_i |=> map_upper_reg == RST_TAG_MAP_UPPER;
	endproperty
	a_reset_upper: assert property (p_reset_upper)
		else $error("upper map reset wrong");

	property p_reset_five;
		@(posedge clk_i) rst_i |=> map_upper_reg[3:2] == 2'h2;
	endproperty
	a_reset_five: assert property (p_reset_five)
		else $error("tag five reset wrong");

	property p_reset_four;
		@(posedge clk_i) rst_i |=> map_upper_reg[1:0] == 2'h2;
	endproperty
	a_reset_four: assert property (p_reset_four)
		else $error("tag four reset wrong");

	property p_four_queue;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !queue_cfg_reg[0] |=> !cls_high_o;
	endproperty
	a_four_queue: assert property (p_four_queue)
		else $error("fold applied outside two-queue mode");

	property p_ds_source;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && frm_use_ds_i |=> cls_prio_o == $past(frm_ds_prio_i);
	endproperty
	a_ds_source: assert property (p_ds_source)
		else $error("DiffServ result not used");

	property p_sel_zero;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && queue_cfg_reg[0] && fold_ctrl_reg[1:0] == 2'h0 |=>
			cls_high_o == (cls_prio_o == 2'h3);
	endproperty
	a_sel_zero: assert property (p_sel_zero)
		else $error("selector 00 fold wrong");

	property p_sel_three;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && queue_cfg_reg[0] && fold_ctrl_reg[1:0] == 2'h3 |=>
			cls_high_o == (cls_prio_o != 2'h0);
	endproperty
	a_sel_three: assert property (p_sel_three)
		else $error("selector 11 fold wrong");

	property p_sel_reset;
		@(posedge clk_i) rst_i |=> fold_ctrl_reg[1:0] == 2'h2;
	endproperty
	a_sel_reset: assert property (p_sel_reset)
		else $error("selector reset wrong");

	property p_sel_two;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && queue_cfg_reg[0] && fold_ctrl_reg[1:0] == 2'h2 |=>
			cls_high_o == cls_prio_o[1];
	endproperty
	a_sel_two: assert property (p_sel_two)
		else $error("selector 10 fold wrong");

	// Checks on the register bus answer; a stuck ack would hang the master
	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");

	property p_answer_excl;
		@(posedge clk_i) disable iff (rst_i)
		!(wb_ack_o && wb_err_o);
	endproperty
	a_answer_excl: assert property (p_answer_excl)
		else $error("ack and err together");

	property p_ack_mapped;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && req && addr_ok |=> wb_ack_o && !wb_err_o;
	endproperty
	a_ack_mapped: assert property (p_ack_mapped)
		else $error("mapped access not acknowledged");

	property p_err_unmapped;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && req && !addr_ok |=> wb_err_o && !wb_ack_o;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped)
		else $error("unmapped access not refused");

	property p_rd_upper;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && req && !wb_we_i && hit_upper |=>
			wb_dat_o == {24'h00_0000, $past(map_upper_reg)};
	endproperty
	a_rd_upper: assert property (p_rd_upper)
		else $error("upper map read wrong");

	property p_wr_seven;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && wr_fire && hit_upper |=>
			map_upper_reg[7:6] == $past(wb_dat_i[7:6]);
	endproperty
	a_wr_seven: assert property (p_wr_seven)
		else $error("tag seven field not written");

	property p_wr_five;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && wr_fire && hit_upper |=>
			map_upper_reg[3:2] == $past(wb_dat_i[3:2]);
	endproperty
	a_wr_five: assert property (p_wr_five)
		else $error("tag five field not written");

	property p_wr_four;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && wr_fire && hit_upper |=>
			map_upper_reg[1:0] == $past(wb_dat_i[1:0]);
	endproperty
	a_wr_four: assert property (p_wr_four)
		else $error("tag four field not written");

	property p_upper_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(ce_i && wr_fire && hit_upper) |=> $stable(map_upper_reg);
	endproperty
	a_upper_hold: assert property (p_upper_hold)
		else $error("upper map changed without a write");

	property p_fold_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(ce_i && wr_fire && hit_fold) |=> $stable(fold_ctrl_reg);
	endproperty
	a_fold_hold: assert property (p_fold_hold)
		else $error("fold control changed without a write");

	// Per-tag lookup; each field must answer only for its own tag
	property p_tag_six;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && frm_tagged_i && !frm_use_ds_i && frm_tag_i == 3'h6 |=>
			cls_prio_o == $past(map_upper_reg[5:4]);
	endproperty
	a_tag_six: assert property (p_tag_six)
		else $error("tag six lookup wrong");

	property p_tag_five;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && frm_tagged_i && !frm_use_ds_i && frm_tag_i == 3'h5 |=>
			cls_prio_o == $past(map_upper_reg[3:2]);
	endproperty
	a_tag_five: assert property (p_tag_five)
		else $error("tag five lookup wrong");

	property p_tag_four;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && frm_tagged_i && !frm_use_ds_i && frm_tag_i == 3'h4 |=>
			cls_prio_o == $past(map_upper_reg[1:0]);
	endproperty
	a_tag_four: assert property (p_tag_four)
		else $error("tag four lookup wrong");

	property p_tag_zero;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && frm_tagged_i && !frm_use_ds_i && frm_tag_i == 3'h0 |=>
			cls_prio_o == $past(map_lower_reg[1:0]);
	endproperty
	a_tag_zero: assert property (p_tag_zero)
		else $error("tag zero lookup wrong");

	// The spare selector code must fold like the default one
	property p_sel_one;
		@(posedge clk_i) disable iff (rst_i)
		ce_i && queue_cfg_reg[0] && fold_ctrl_reg[1:0] == 2'h1 |=>
			cls_high_o == cls_prio_o[1];
	endproperty
	a_sel_one: assert property (p_sel_one)
		else $error("selector 01 fold wrong");
endmodule : tag_priority_queue_map
`default_nettype wire

// file: test_tag_priority_queue_map.sv
// Self-checking bench for the tag priority queue map register bank
`timescale 1ns/1ps
`default_nettype none
module test_tag_priority_queue_map;
	import tag_prio_pkg::*;
	logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [BUS_ADDR_W-1:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic wb_ack_o, wb_err_o, frm_valid_i, frm_tagged_i, frm_use_ds_i;
	logic [2:0] frm_tag_i;
	logic [1:0] frm_ds_prio_i, cls_prio_o;
	logic cls_valid_o, cls_high_o;
	int err_total = 0;
	int samples_checked = 0;

	// 200 MHz core clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	tag_priority_queue_map tag_priority_queue_map_i (.clk_i(clk_i),
		.rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o), .frm_valid_i(frm_valid_i),
		.frm_tagged_i(frm_tagged_i), .frm_tag_i(frm_tag_i),
		.frm_use_ds_i(frm_use_ds_i), .frm_ds_prio_i(frm_ds_prio_i),
		.cls_valid_o(cls_valid_o), .cls_prio_o(cls_prio_o),
		.cls_high_o(cls_high_o));

	task end_of_test;
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Expected queue from the selector encodings; 01 is read as 10
	function automatic logic hi(input logic [1:0] r, input logic [1:0] s);
		case (s)
			2'h0: return r == 2'h3;
			2'h3: return r != 2'h0;
			default: return r[1];
		endcase
	endfunction : hi

	// Classic cycle; outputs are read before the edge's own updates land
	task bus(input logic we, input logic [9:0] adr, input logic [7:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h000000, wd};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_total++;
			end_of_test;
		end else begin
			rd = wb_dat_o;
			er = wb_err_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
			wb_we_i <= 1'b0;
		end
	endtask : bus

	task wr(input logic [9:0] adr, input logic [7:0] wd);
		logic [31:0] d;
		logic e;
		bus(1'b1, adr, wd, d, e);
	endtask : wr

	task rd(input logic [9:0] adr, input logic [31:0] exp);
		logic [31:0] d;
		logic e;
		bus(1'b0, adr, 8'h00, d, e);
		chk(d, exp);
	endtask : rd

	// One frame in, result compared one cycle later
	task cls(input logic tg, input logic [2:0] tag, input logic ds,
		input logic [1:0] dp, input logic [1:0] ep, input logic eh);
		@(posedge clk_i);
		frm_valid_i <= 1'b1;
		frm_tagged_i <= tg;
		frm_tag_i <= tag;
		frm_use_ds_i <= ds;
		frm_ds_prio_i <= dp;
		@(posedge clk_i);
		frm_valid_i <= 1'b0;
		@(posedge clk_i);
		chk({29'h0, cls_valid_o, cls_prio_o}, {29'h0, 1'b1, ep});
		chk({31'h0, cls_high_o}, {31'h0, eh});
	endtask : cls

	task t_reset_and_default;
		rd(10'h204, 32'h000000fa);
		rd(10'h208, 32'h00000002);
		wr(10'h20c, 8'h01);
		for (int i = 0; i < 4; i++)
			cls(1'b0, 3'h0, 1'b1, i[1:0], i[1:0], i >= 2);
	endtask : t_reset_and_default

	// Distinct value per tag from four to seven, with a different DiffServ value alongside
	task t_tag_map;
		wr(10'h204, 8'h1b);
		rd(10'h204, 32'h0000001b);
		for (int t = 4; t < 8; t++)
			cls(1'b1, t[2:0], 1'b0, t[1:0], 2'(7 - t), (7 - t) >= 2);
	endtask : t_tag_map

	task t_fold_table;
		logic [1:0] s;
		logic [1:0] r;
		for (int k = 0; k < 4; k++) begin
			s = k[1:0];
			wr(10'h208, {6'h00, s});
			for (int i = 0; i < 4; i++) begin
				r = i[1:0];
				cls(1'b1, {1'b1, r}, 1'b1, r, r, hi(r, s));
				cls(1'b1, 3'h7 - {1'b0, r}, 1'b0, ~r, r, hi(r, s));
			end
		end
	endtask : t_fold_table

	// Four queues: no fold; then an unmapped place leaves the map alone
	task t_four_queue_and_unmapped;
		logic [31:0] d;
		logic e;
		wr(10'h20c, 8'h00);
		cls(1'b0, 3'h0, 1'b1, 2'h3, 2'h3, 1'b0);
		rd(10'h210, 32'h00000003);
		bus(1'b1, 10'h3fc, 8'h55, d, e);
		chk({31'h0, e}, 32'h1);
		rd(10'h204, 32'h0000001b);
	endtask : t_four_queue_and_unmapped

	initial begin
		{ce_i, rst_i} = 2'b11;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 7'h00;
		wb_adr_i = '0;
		wb_dat_i = 32'h00000000;
		{frm_valid_i, frm_tagged_i, frm_use_ds_i} = 3'h0;
		frm_tag_i = 3'h0;
		frm_ds_prio_i = 2'h0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_and_default;
		t_tag_map;
		t_fold_table;
		t_four_queue_and_unmapped;
		end_of_test;
	end
endmodule : test_tag_priority_queue_map
`default_nettype wire
